// *** rtl/adc_pkg.sv ***
// Shared constants, types and lookup tables for the decoder control block
package adc_pkg;

	// ==========================================================
	// Serial frame opcodes and register indices
	localparam logic [7:0] OP_WRITE        = 8'h02;
	localparam logic [7:0] OP_READ         = 8'h03;
	localparam logic [7:0] REG_MODE        = 8'h00;
	localparam logic [7:0] REG_CLOCK_CFG   = 8'h03;
	localparam logic [7:0] REG_DECODE_TIME = 8'h04;
	localparam logic [7:0] REG_AUDIO_FMT   = 8'h05;
	localparam logic [7:0] REG_MEM_DATA    = 8'h06;
	localparam logic [7:0] REG_MEM_ADDR    = 8'h07;
	localparam logic [7:0] REG_HDR_LOW     = 8'h08;
	localparam logic [7:0] REG_HDR_HIGH    = 8'h09;
	localparam logic [7:0] REG_APP_START   = 8'h0a;

	// ==========================================================
	// Field positions and reset values
	localparam int MULT_MSB       = 15;
	localparam int MULT_LSB       = 13;
	localparam int ADD_MSB        = 12;
	localparam int ADD_LSB        = 11;
	localparam int FREQ_MSB       = 10;
	localparam int SOFT_RESET_BIT = 2;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [1:0]  INSTR_SEL  = 2'b10;

	// Input clock code assumed when the frequency field is zero
	localparam int XTAL_DEFAULT_HZ = 12288000;
	localparam int FREQ_BASE_HZ    = 8000000;
	localparam int FREQ_STEP_HZ    = 4000;
	localparam logic [10:0] FREQ_DEFAULT =
		11'((XTAL_DEFAULT_HZ - FREQ_BASE_HZ) / FREQ_STEP_HZ);

	// ==========================================================
	// Fixed header words per format
	localparam logic [15:0] WAV_LOW   = 16'h7761;
	localparam logic [15:0] WAV_HIGH  = 16'h7665;
	localparam logic [15:0] WMA_HIGH  = 16'h574d;
	localparam logic [15:0] MIDI_HIGH = 16'h4d54;

	// ==========================================================
	// Host serial timing in reference clock cycles
	localparam int SCLK_HALF_CYC = 8;
	localparam int GAP_CYC       = 4;

	// ==========================================================
	// Stream header decode tables, bitrate index 0 and 15 and sample rate index 3 carry no rate
	localparam logic [15:0] RATE_BASE [4] =
		'{16'hac44, 16'hbb80, 16'h7d00, 16'h0000};
	localparam logic [8:0] KBPS_V1 [16] = '{9'h000, 9'h020, 9'h028,
		9'h030, 9'h038, 9'h040, 9'h050, 9'h060, 9'h070, 9'h080,
		9'h0a0, 9'h0c0, 9'h0e0, 9'h100, 9'h140, 9'h000};
	localparam logic [8:0] KBPS_V2 [16] = '{9'h000, 9'h008, 9'h010,
		9'h018, 9'h020, 9'h028, 9'h030, 9'h038, 9'h040, 9'h050,
		9'h060, 9'h070, 9'h080, 9'h090, 9'h0a0, 9'h000};

	typedef enum logic [2:0] {
		FMT_NONE = 3'b000,
		FMT_WAV  = 3'b001,
		FMT_WMA  = 3'b010,
		FMT_MIDI = 3'b011,
		FMT_MP3  = 3'b100
	} adc_fmt_type;

	typedef enum logic [1:0] {
		HST_IDLE  = 2'b00,
		HST_SHIFT = 2'b01,
		HST_GAP   = 2'b10
	} adc_hst_type;

endpackage : adc_pkg

// *** rtl/adc_sci_if.sv ***
// Serial control link between host and decoder control block
`timescale 1ns/1ps
interface adc_sci_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso;
	modport device (input cs_n, input sclk, input mosi, output miso);
	modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : adc_sci_if

// *** rtl/adc_device.sv ***
// Decoder-side control registers reached over the serial control link
`timescale 1ns/1ps
module adc_device (
	input  wire logic                ref_clk_i,
	input  wire logic                nrst_i,
	adc_sci_if.device                sci,
	input  wire adc_pkg::adc_fmt_type fmt_i,
	input  wire logic                decoding_i,
	input  wire logic                second_tick_i,
	input  wire logic                boost_up_i,
	input  wire logic                boost_down_i,
	input  wire logic                rate_update_i,
	input  wire logic [14:0]         rate_half_i,
	input  wire logic                stereo_i,
	input  wire logic                hdr_update_i,
	input  wire logic [31:0]         mp3_hdr_i,
	input  wire logic [15:0]         wma_byte_rate_i,
	input  wire logic [7:0]          midi_poly_i,
	input  wire logic [31:0]         mem_rdata_i,
	output logic [3:0]               core_mult_o,
	output logic [10:0]              input_freq_o,
	output logic [15:0]              sample_rate_o,
	output logic                     stereo_o,
	output logic [15:0]              mem_addr_o,
	output logic [31:0]              mem_wdata_o,
	output logic                     mem_we_o,
	output logic                     mem_re_o,
	output logic [15:0]              app_start_o,
	output logic                     soft_reset_o
);
	import adc_pkg::*;

	// ==========================================================
	// Pin synchronisers and serial frame capture
	logic [2:0]  cs_s;
	logic [2:0]  sck_s;
	logic [1:0]  mosi_s;
	logic [5:0]  bit_cnt;
	logic [15:0] in_sr;
	logic [15:0] out_sr;
	logic [7:0]  op_q;
	logic [7:0]  addr_q;
	logic        miso_q;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cs_s   <= 3'h7;
			sck_s  <= 3'h0;
			mosi_s <= 2'h0;
		end else begin
			cs_s   <= {cs_s[1:0], sci.cs_n};
			sck_s  <= {sck_s[1:0], sci.sclk};
			mosi_s <= {mosi_s[0], sci.mosi};
		end
	end

	// Edges come from stages 1 and 2 so stage 0 feeds only stage 1
	wire         sck_rise = sck_s[1] & ~sck_s[2];
	wire         sck_fall = ~sck_s[1] & sck_s[2];
	wire         cs_idle  = cs_s[1];
	wire [15:0]  next_sr  = {in_sr[14:0], mosi_s[1]};
	wire         cmd_done = sck_rise && !cs_idle && bit_cnt == 6'd15;
	wire         rd_stb   = cmd_done && next_sr[15:8] == OP_READ;
	wire         wr_stb   = sck_rise && !cs_idle && bit_cnt == 6'd31
		&& op_q == OP_WRITE;
	wire [7:0]   rd_addr  = next_sr[7:0];
	wire         rd_phase = op_q == OP_READ && bit_cnt >= 6'd16;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bit_cnt <= 6'h00;
			in_sr   <= RESET_WORD;
			op_q    <= 8'h00;
			addr_q  <= 8'h00;
		end else if (cs_idle) begin
			bit_cnt <= 6'h00;
		end else if (sck_rise) begin
			in_sr   <= next_sr;
			bit_cnt <= bit_cnt + 6'h01;
			if (cmd_done) begin
				op_q   <= next_sr[15:8];
				addr_q <= next_sr[7:0];
			end
		end
	end

	// ==========================================================
	// Register state
	logic [2:0]  cfg_mult;
	logic [1:0]  cfg_add;
	logic [10:0] cfg_freq;
	logic [15:0] decode_time;
	logic [14:0] rate_half;
	logic        stereo;
	logic [15:0] hdr_low;
	logic [15:0] hdr_high;
	logic        srst;
	logic        dec_q;
	logic        half;
	logic [15:0] hi_q;
	logic [15:0] rd_val;

	wire dec_edge  = decoding_i ^ dec_q;
	wire instr     = mem_addr_o[15:14] == INSTR_SEL;
	wire mem_wr    = wr_stb && addr_q == REG_MEM_DATA;
	wire mem_rd    = rd_stb && rd_addr == REG_MEM_DATA;
	wire [3:0] cap = 4'({1'b0, cfg_mult} + {2'b00, cfg_add});

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_mult     <= 3'h0;
			cfg_add      <= 2'h0;
			cfg_freq     <= 11'h000;
			input_freq_o <= FREQ_DEFAULT;
		end else begin
			if (wr_stb && addr_q == REG_CLOCK_CFG) begin
				cfg_mult <= in_sr[MULT_MSB-1:MULT_LSB-1];
				cfg_add  <= in_sr[ADD_MSB-1:ADD_LSB-1];
				cfg_freq <= {in_sr[FREQ_MSB-1:0], mosi_s[1]};
			end
			input_freq_o <= (cfg_freq == 11'h000) ? FREQ_DEFAULT
				: cfg_freq;
		end
	end

	// Multiplier in half-steps above 1.0; boost never dips below
	// the configured value so the serial clock stays safe in-file
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			core_mult_o <= 4'h0;
			dec_q       <= 1'b0;
		end else begin
			dec_q <= decoding_i;
			if (wr_stb && addr_q == REG_CLOCK_CFG)
				core_mult_o <= {1'b0, next_sr[MULT_MSB:MULT_LSB]};
			else if (dec_q && !decoding_i)
				core_mult_o <= {1'b0, cfg_mult};
			else if (decoding_i && fmt_i == FMT_WMA) begin
				if (boost_up_i && core_mult_o < cap)
					core_mult_o <= core_mult_o + 4'h1;
				else if (boost_down_i && core_mult_o > {1'b0, cfg_mult})
					core_mult_o <= core_mult_o - 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			decode_time <= RESET_WORD;
		end else if (srst || (dec_edge && (fmt_i == FMT_WAV
			|| fmt_i == FMT_WMA || fmt_i == FMT_MIDI))) begin
			decode_time <= RESET_WORD;
		end else if (wr_stb && addr_q == REG_DECODE_TIME) begin
			decode_time <= next_sr;
		end else if (decoding_i && second_tick_i) begin
			decode_time <= decode_time + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rate_half     <= 15'h0000;
			stereo        <= 1'b0;
			sample_rate_o <= RESET_WORD;
			stereo_o      <= 1'b0;
		end else begin
			if (wr_stb && addr_q == REG_AUDIO_FMT)
				rate_half <= next_sr[15:1];
			else if (rate_update_i) begin
				rate_half <= rate_half_i;
				stereo    <= stereo_i;
			end
			sample_rate_o <= {rate_half, 1'b0};
			// Known quirk kept on purpose: odd code flips the sense
			stereo_o      <= stereo ^ rate_half[0];
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hdr_low  <= RESET_WORD;
			hdr_high <= RESET_WORD;
		end else if (srst) begin
			hdr_low  <= RESET_WORD;
			hdr_high <= RESET_WORD;
		end else if (hdr_update_i) begin
			case (fmt_i)
				FMT_WAV: begin
					hdr_low  <= WAV_LOW;
					hdr_high <= WAV_HIGH;
				end
				FMT_WMA: begin
					hdr_low  <= wma_byte_rate_i;
					hdr_high <= WMA_HIGH;
				end
				FMT_MIDI: begin
					hdr_low  <= {8'h00, midi_poly_i};
					hdr_high <= MIDI_HIGH;
				end
				FMT_MP3: begin
					hdr_low  <= mp3_hdr_i[15:0];
					hdr_high <= mp3_hdr_i[31:16];
				end
				default: begin
					hdr_low  <= hdr_low;
					hdr_high <= hdr_high;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			srst         <= 1'b0;
			soft_reset_o <= 1'b0;
			app_start_o  <= RESET_WORD;
		end else begin
			// One-cycle pulse, so the mode bit clears by itself
			srst <= wr_stb && addr_q == REG_MODE
				&& next_sr[SOFT_RESET_BIT];
			soft_reset_o <= srst;
			if (wr_stb && addr_q == REG_APP_START)
				app_start_o <= next_sr;
		end
	end

	// ==========================================================
	// Indirect memory port: pointer moves after each full word
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mem_addr_o  <= RESET_WORD;
			mem_wdata_o <= 32'h00000000;
			mem_we_o    <= 1'b0;
			mem_re_o    <= 1'b0;
			half        <= 1'b0;
			hi_q        <= RESET_WORD;
		end else begin
			mem_we_o <= 1'b0;
			mem_re_o <= mem_rd && !(instr && half);
			if (wr_stb && addr_q == REG_MEM_ADDR) begin
				mem_addr_o <= next_sr;
				half       <= 1'b0;
			end else if (mem_we_o) begin
				// Step only after the strobe has used the old address
				mem_addr_o <= mem_addr_o + 16'h0001;
			end else if ((mem_wr || mem_rd) && instr && !half) begin
				half <= 1'b1;
				hi_q <= mem_wr ? next_sr : mem_rdata_i[15:0];
			end else if (mem_wr || mem_rd) begin
				half       <= 1'b0;
				if (mem_rd)
					mem_addr_o <= mem_addr_o + 16'h0001;
				mem_we_o   <= mem_wr;
				mem_wdata_o <= instr ? {hi_q, next_sr}
					: {16'h0000, next_sr};
			end
		end
	end

	// ==========================================================
	// Read data and serial output
	always_comb begin
		rd_val = RESET_WORD;
		case (rd_addr)
			REG_MODE:        rd_val = 16'(srst) << SOFT_RESET_BIT;
			REG_CLOCK_CFG:   rd_val = {cfg_mult, cfg_add, cfg_freq};
			REG_DECODE_TIME: rd_val = decode_time;
			REG_AUDIO_FMT:   rd_val = {rate_half, stereo};
			REG_MEM_DATA: begin
				if (instr && half)
					rd_val = hi_q;
				else if (instr)
					rd_val = mem_rdata_i[31:16];
				else
					rd_val = mem_rdata_i[15:0];
			end
			REG_HDR_LOW:     rd_val = hdr_low;
			REG_HDR_HIGH:    rd_val = hdr_high;
			REG_APP_START:   rd_val = app_start_o;
			default:         rd_val = RESET_WORD;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			out_sr <= RESET_WORD;
			miso_q <= 1'b0;
		end else if (cs_idle) begin
			miso_q <= 1'b0;
		end else if (rd_stb) begin
			out_sr <= rd_val;
		end else if (sck_fall && rd_phase) begin
			miso_q <= out_sr[15];
			out_sr <= {out_sr[14:0], 1'b0};
		end
	end

	assign sci.miso = miso_q;

endmodule : adc_device

// *** rtl/adc_host.sv ***
// Host-side serial control master with header decode
`timescale 1ns/1ps
module adc_host (
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	adc_sci_if.host          sci,
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_write_i,
	input  wire logic [7:0]  cmd_addr_i,
	input  wire logic [15:0] cmd_wdata_i,
	output logic             cmd_ready_o,
	output logic             rsp_valid_o,
	output logic [15:0]      rsp_rdata_o,
	output logic             refused_o,
	output logic [15:0]      mp3_rate_hz_o,
	output logic [8:0]       mp3_kbps_o
);
	import adc_pkg::*;

	// ==========================================================
	// Frame engine
	adc_hst_type state;
	logic [1:0]  miso_s;
	logic [31:0] frame;
	logic [31:0] cmd_q;
	logic [15:0] rx;
	logic [7:0]  div;
	logic [4:0]  bit_cnt;
	logic        rpt;
	logic        addr_loaded;
	logic [1:0]  hdr_id;
	logic        cs_n_q;
	logic        sclk_q;
	logic        mosi_q;

	wire accept = cmd_valid_i && cmd_ready_o;
	wire bad    = cmd_addr_i == REG_MEM_DATA && !addr_loaded;
	wire tick   = div == 8'(SCLK_HALF_CYC - 1);
	wire [1:0] rsh = (hdr_id == 2'h3) ? 2'h0
		: ((hdr_id == 2'h2) ? 2'h1 : 2'h2);

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			miso_s <= 2'h0;
		else
			miso_s <= {miso_s[0], sci.miso};
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state       <= HST_IDLE;
			cmd_ready_o <= 1'b0;
			rsp_valid_o <= 1'b0;
			rsp_rdata_o <= RESET_WORD;
			refused_o   <= 1'b0;
			frame       <= 32'h00000000;
			cmd_q       <= 32'h00000000;
			rx          <= RESET_WORD;
			div         <= 8'h00;
			bit_cnt     <= 5'h00;
			rpt         <= 1'b0;
			addr_loaded <= 1'b0;
			cs_n_q      <= 1'b1;
			sclk_q      <= 1'b0;
			mosi_q      <= 1'b0;
		end else begin
			rsp_valid_o <= 1'b0;
			refused_o   <= 1'b0;
			case (state)
				HST_IDLE: begin
					cmd_ready_o <= 1'b1;
					if (accept && bad) begin
						refused_o <= 1'b1;
					end else if (accept) begin
						cmd_ready_o <= 1'b0;
						frame  <= {cmd_write_i ? OP_WRITE : OP_READ,
							cmd_addr_i, cmd_wdata_i};
						cmd_q  <= {cmd_write_i ? OP_WRITE : OP_READ,
							cmd_addr_i, cmd_wdata_i};
						mosi_q <= cmd_write_i ? OP_WRITE[7] : OP_READ[7];
						// A new decode time is sent twice
						rpt <= cmd_write_i
							&& cmd_addr_i == REG_DECODE_TIME;
						if (cmd_write_i && cmd_addr_i == REG_MEM_ADDR)
							addr_loaded <= 1'b1;
						cs_n_q  <= 1'b0;
						div     <= 8'h00;
						bit_cnt <= 5'h00;
						state   <= HST_SHIFT;
					end
				end
				HST_SHIFT: begin
					div <= tick ? 8'h00 : div + 8'h01;
					if (tick && !sclk_q) begin
						sclk_q <= 1'b1;
						rx     <= {rx[14:0], miso_s[1]};
					end else if (tick) begin
						sclk_q  <= 1'b0;
						frame   <= {frame[30:0], 1'b0};
						mosi_q  <= frame[30];
						bit_cnt <= bit_cnt + 5'h01;
						if (bit_cnt == 5'h1f) begin
							cs_n_q <= 1'b1;
							state  <= HST_GAP;
						end
					end
				end
				HST_GAP: begin
					div <= div + 8'h01;
					if (div == 8'(GAP_CYC - 1)) begin
						div <= 8'h00;
						if (rpt) begin
							rpt     <= 1'b0;
							frame   <= cmd_q;
							mosi_q  <= cmd_q[31];
							cs_n_q  <= 1'b0;
							bit_cnt <= 5'h00;
							state   <= HST_SHIFT;
						end else begin
							rsp_valid_o <= 1'b1;
							rsp_rdata_o <= rx;
							cmd_ready_o <= 1'b1;
							state       <= HST_IDLE;
						end
					end
				end
				default: state <= HST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Stream header decode from completed header reads
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hdr_id        <= 2'h0;
			mp3_rate_hz_o <= RESET_WORD;
			mp3_kbps_o    <= 9'h000;
		end else if (state == HST_GAP && !rpt
			&& div == 8'(GAP_CYC - 1) && cmd_q[31:24] == OP_READ) begin
			if (cmd_q[23:16] == REG_HDR_HIGH)
				hdr_id <= rx[4:3];
			else if (cmd_q[23:16] == REG_HDR_LOW) begin
				mp3_rate_hz_o <= RATE_BASE[rx[11:10]] >> rsh;
				mp3_kbps_o <= (hdr_id == 2'h3) ? KBPS_V1[rx[15:12]]
					: KBPS_V2[rx[15:12]];
			end
		end
	end

	assign sci.cs_n = cs_n_q;
	assign sci.sclk = sclk_q;
	assign sci.mosi = mosi_q;

endmodule : adc_host

// *** dv/adc_sci_props.sv ***
// Wire-level checks on the serial control link between host and device
`timescale 1ns/1ps
module adc_sci_props (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso
);
	logic       sclk_q;
	logic [5:0] rise_cnt;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	// ==========================================================
	// Rising serial clock edges seen in the current frame
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sclk_q   <= 1'b0;
			rise_cnt <= 6'h00;
		end else begin
			sclk_q <= sclk;
			if (cs_n)
				rise_cnt <= 6'h00;
			else if (sclk && !sclk_q)
				rise_cnt <= rise_cnt + 6'h01;
		end
	end

	// ==========================================================
	// Frame shape
	chk_idle_clock_low: assert property (cs_n |-> !sclk)
		else $error("serial clock high outside a frame");
	chk_high_half_len: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
		else $error("serial clock high phase not eight cycles");
	chk_low_half_min: assert property ($fell(sclk) |-> !sclk[*8])
		else $error("serial clock low phase too short");
	chk_mosi_hold: assert property (sclk |-> $stable(mosi))
		else $error("host data moved while clock high");
	chk_miso_hold: assert property (sclk |-> $stable(miso))
		else $error("device data moved while clock high");
	chk_frame_bits: assert property ($rose(cs_n) |-> rise_cnt == 6'h20)
		else $error("frame did not carry 32 bits");
	chk_opcode_lead: assert property ($fell(cs_n) |-> !mosi)
		else $error("opcode top bit not zero at frame start");
	chk_frame_gap: assert property ($rose(cs_n) |-> cs_n[*4])
		else $error("frames closer than the gap");

	cover property ($rose(cs_n));
	cover property ($fell(cs_n) ##[1:600] (sclk && miso));
	cover property ($rose(sclk) && mosi);
endmodule : adc_sci_props

// *** dv/audio_decoder_control_regs_tb.sv ***
// Self-checking bench joining host and device ends of the control link
`timescale 1ns/1ps
module audio_decoder_control_regs_tb;
	import adc_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        nrst_i, cmd_valid, cmd_write, ready, rsp_valid, refused;
	logic [7:0]  cmd_addr, poly;
	logic [15:0] cmd_wdata, rdata, rate_hz, wma_rate, srate, maddr, app;
	logic [8:0]  kbps;
	adc_fmt_type fmt;
	logic        decoding, tick, b_up, b_dn, r_upd, h_upd, stereo;
	logic        st, we, re, sr, sr_seen;
	logic [14:0] r_half;
	logic [31:0] mp3_hdr, wdata;
	logic [3:0]  mult;
	logic [10:0] freq;
	logic [47:0] wq[$];
	int unsigned seed = 38;
	int          n_errors = 0;
	int          compares = 0;
	int          n_re = 0;
	int          kb1[15] = '{0, 32, 40, 48, 56, 64, 80, 96, 112, 128, 160,
		192, 224, 256, 320};
	int          kb2[15] = '{0, 8, 16, 24, 32, 40, 48, 56, 64, 80, 96,
		112, 128, 144, 160};
	int          base[3] = '{44100, 48000, 32000};

	adc_sci_if sci_if_i ();
	adc_device adc_device_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.sci(sci_if_i), .fmt_i(fmt), .decoding_i(decoding),
		.second_tick_i(tick), .boost_up_i(b_up), .boost_down_i(b_dn),
		.rate_update_i(r_upd), .rate_half_i(r_half), .stereo_i(stereo),
		.hdr_update_i(h_upd), .mp3_hdr_i(mp3_hdr), .wma_byte_rate_i(wma_rate),
		.midi_poly_i(poly), .mem_rdata_i({~maddr, maddr}), .core_mult_o(mult),
		.input_freq_o(freq), .sample_rate_o(srate), .stereo_o(st),
		.mem_addr_o(maddr), .mem_wdata_o(wdata), .mem_we_o(we), .mem_re_o(re),
		.app_start_o(app), .soft_reset_o(sr));
	adc_host adc_host_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.sci(sci_if_i), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
		.cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .cmd_ready_o(ready),
		.rsp_valid_o(rsp_valid), .rsp_rdata_o(rdata), .refused_o(refused),
		.mp3_rate_hz_o(rate_hz), .mp3_kbps_o(kbps));
	adc_sci_props adc_sci_props_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.cs_n(sci_if_i.cs_n), .sclk(sci_if_i.sclk), .mosi(sci_if_i.mosi),
		.miso(sci_if_i.miso));

	always #5 ref_clk_i = ~ref_clk_i;

	// Memory strobes are single-cycle, so they are logged as they occur
	always @(posedge ref_clk_i) begin
		if (we === 1'b1)
			wq.push_back({maddr, wdata});
		if (sr === 1'b1)
			sr_seen = 1'b1;
		if (re === 1'b1)
			n_re++;
	end

	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic chk(input string nm, input logic [47:0] e,
		input logic [47:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic rf);
		int n;
		for (n = 0; n < 50 && ready !== 1'b1; n++)
			@(negedge ref_clk_i);
		{cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, wr, a, d};
		@(negedge ref_clk_i);
		cmd_valid = 1'b0;
		for (n = 0; n < 1200 && rsp_valid !== 1'b1 && refused !== 1'b1; n++)
			@(negedge ref_clk_i);
		chk("response", 1, 48'(n < 1200));
		q = rdata;
		rf = refused;
		@(negedge ref_clk_i);
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		logic        rf;
		xfer(1'b1, a, d, q, rf);
	endtask : wr

	task automatic rd(input string nm, input logic [7:0] a,
		input logic [15:0] e);
		logic [15:0] q;
		logic        rf;
		xfer(1'b0, a, 16'h0000, q, rf);
		chk(nm, e, q);
	endtask : rd

	task automatic pulse(input int sel, input int k);
		repeat (k) begin
			{h_upd, r_upd, b_dn, b_up, tick} = 5'h01 << sel;
			@(negedge ref_clk_i);
			{h_upd, r_upd, b_dn, b_up, tick} = 5'h00;
			@(negedge ref_clk_i);
		end
	endtask : pulse

	task automatic wrap_up();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (100000) @(posedge ref_clk_i);
		n_errors++;
		$display("[ERR] run expected done seen timeout");
		wrap_up();
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] v, w;
		logic [15:0] q, lo;
		logic        r;
		logic [47:0] e;
		int          i, m, br, sx;
		{nrst_i, cmd_valid, cmd_write, cmd_addr, cmd_wdata} = '0;
		{decoding, tick, b_up, b_dn, r_upd, h_upd, stereo, sr_seen} = '0;
		{r_half, mp3_hdr, wma_rate, poly} = '0;
		fmt = FMT_NONE;
		repeat (2) @(negedge ref_clk_i);
		nrst_i = 1'b1;
		repeat (2) @(negedge ref_clk_i);
		chk("input_freq", 11'h430, freq);
		xfer(1'b0, REG_MEM_DATA, 16'h0000, q, r);
		chk("refused", 1, r);
		for (i = 3; i < 16; i++)
			if (i != 6 && i != 7)
				rd("reset_value", 8'(i), 16'h0000);
		v = rnd();
		wr(REG_CLOCK_CFG, v[15:0]);
		rd("clock_config", REG_CLOCK_CFG, v[15:0]);
		chk("core_mult", v[15:13], mult);
		chk("input_freq", v[10:0] == 11'h000 ? 11'h430 : v[10:0],
			freq);
		fmt = FMT_WMA;
		decoding = 1'b1;
		for (i = 0; i < 4; i++) begin
			m = rnd() % 6;
			wr(REG_CLOCK_CFG, {3'(m), 2'(i), 11'h000});
			chk("input_freq", 11'h430, freq);
			pulse(1, 5);
			chk("boosted_mult", m + i, mult);
			pulse(2, 5);
			chk("restored_mult", m, mult);
		end
		fmt = FMT_MP3;
		pulse(1, 2);
		chk("non_wma_mult", m, mult);
		fmt = FMT_WMA;
		pulse(1, 1);
		chk("step_mult", m + 1, mult);
		decoding = 1'b0;
		pulse(0, 2);
		chk("end_mult", m, mult);
		decoding = 1'b1;
		@(negedge ref_clk_i);
		m = 1 + rnd() % 6;
		pulse(0, m);
		rd("decode_time", REG_DECODE_TIME, 16'(m));
		w = rnd();
		wr(REG_DECODE_TIME, w[15:0]);
		rd("decode_time", REG_DECODE_TIME, w[15:0]);
		decoding = 1'b0;
		@(negedge ref_clk_i);
		rd("decode_time", REG_DECODE_TIME, 16'h0000);
		v = rnd();
		{r_half, stereo} = v[15:0];
		pulse(3, 1);
		rd("audio_format", REG_AUDIO_FMT, v[15:0]);
		chk("stereo", v[0] ^ v[1], st);
		w = rnd();
		wr(REG_AUDIO_FMT, w[15:0]);
		chk("sample_rate", {w[15:1], 1'b0}, srate);
		chk("stereo", v[0] ^ w[1], st);
		rd("audio_format", REG_AUDIO_FMT, {w[15:1], v[0]});
		v = rnd();
		wr(REG_MEM_ADDR, 16'h8030);
		wr(REG_MEM_DATA, v[31:16]);
		wr(REG_MEM_DATA, v[15:0]);
		chk("mem_writes", 1, 48'(wq.size()));
		chk("mem_word", {16'h8030, v}, wq.pop_front());
		chk("mem_pointer", 16'h8031, maddr);
		for (i = 0; i < 3; i++) begin
			lo = i == 0 ? 16'h1800 : (i == 1 ? 16'h5800 : 16'hc000);
			wr(REG_MEM_ADDR, lo);
			wr(REG_MEM_DATA, v[15:0] + 16'(i));
			wr(REG_MEM_DATA, v[31:16]);
			chk("mem_writes", 2, 48'(wq.size()));
			e = wq.pop_front();
			chk("mem_word", {lo, 16'h0000, v[15:0] + 16'(i)}, e);
			e = wq.pop_front();
			chk("mem_word", {lo + 16'h1, 16'h0000, v[31:16]}, e);
		end
		wr(REG_MEM_ADDR, 16'h8040);
		rd("mem_read_hi", REG_MEM_DATA, 16'h7fbf);
		rd("mem_read_lo", REG_MEM_DATA, 16'h8040);
		chk("mem_pointer", 16'h8041, maddr);
		chk("mem_reads", 1, 48'(n_re));
		{wma_rate, poly} = rnd();
		for (i = 0; i < 3; i++) begin
			fmt = adc_fmt_type'(i + 1);
			pulse(4, 1);
			lo = i == 0 ? 16'h7761 : (i == 1 ? wma_rate : {8'h00, poly});
			rd("header_high", REG_HDR_HIGH, i == 0 ? 16'h7665 :
				(i == 1 ? 16'h574d : 16'h4d54));
			rd("header_low", REG_HDR_LOW, lo);
		end
		fmt = FMT_MP3;
		for (i = 0; i < 4; i++) begin
			v = rnd();
			br = 1 + rnd() % 14;
			sx = rnd() % 3;
			mp3_hdr = {11'h7ff, 2'(i), v[2:0], 4'(br), 2'(sx), v[9:0]};
			pulse(4, 1);
			rd("header_high", REG_HDR_HIGH, mp3_hdr[31:16]);
			rd("header_low", REG_HDR_LOW, mp3_hdr[15:0]);
			chk("rate_hz", base[sx] >> (i == 3 ? 0 : (i == 2 ? 1 : 2)),
				rate_hz);
			chk("kbps", i == 3 ? kb1[br] : kb2[br], kbps);
		end
		decoding = 1'b1;
		pulse(0, 2);
		rd("decode_time", REG_DECODE_TIME, 16'h0002);
		wr(REG_MODE, 16'h0004);
		chk("soft_reset_seen", 1, sr_seen);
		rd("mode", REG_MODE, 16'h0000);
		rd("decode_time", REG_DECODE_TIME, 16'h0000);
		rd("header_high", REG_HDR_HIGH, 16'h0000);
		rd("header_low", REG_HDR_LOW, 16'h0000);
		w = rnd();
		wr(REG_APP_START, w[15:0]);
		rd("application_start", REG_APP_START, w[15:0]);
		chk("app_start", w[15:0], app);
		wrap_up();
	end
endmodule : audio_decoder_control_regs_tb
